// ==== rtl/ssp_top.sv ====
// two serial station ports with apb configuration and interrupt
//
// Decided for this implementation: the address map and the APB slave port.
`timescale 1ns/1ns
// Operation
// - two independent ports, each with its own full configuration set.
// - each port holds station address 1..254, default 1, answers to it as slave.
// - a frame to station zero is a broadcast for every slave.
// - a slave accepts station-zero frames whatever its own address.
// - stop-to-run option, default, starts port on run entry.
// - power-on option starts port right after power-up.
// - baud from list, default 9600, or custom 1..5000 x0.1kbps.
// - framing defaults seven data bits, even parity, one stop, ascii.
// - reply waits configurable 0..3000 ms, default 0.
// - as requester, raise timeout after 1..3000 ms, 0 disables it, default 200.
module ssp_top import ssp_pkg::*; #(
  parameter int MS_CYC = MS_CYCLES
) (
  // apb
  input  wire logic                      pclk,
  input  wire logic                      presetn,
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [7:0]                paddr,
  input  wire logic [31:0]               pwdata,
  output logic [31:0]                    prdata,
  output logic                           pready,
  output logic                           pslverr,
  // system state
  input  wire logic                      cpu_run,
  // link side per port
  input  wire ssp_frame_type [PORTS-1:0] rx_frame,
  input  wire logic [PORTS-1:0]          req_sent,
  input  wire logic [PORTS-1:0]          resp_rx,
  output logic [PORTS-1:0]               reply_go,
  output logic [PORTS-1:0]               port_active,
  output ssp_cfg_type [PORTS-1:0]        port_cfg,
  // interrupt
  output logic                           irq
);

  localparam int PRE_W = $clog2(MS_CYC + 1);
  localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(MS_CYC - 1);

  // --------------------------------------------------------------
  // address decode
  // --------------------------------------------------------------
  function automatic ssp_sel_type reg_sel(input logic [7:0] a);
    ssp_sel_type s;
    logic [7:0]  lo;
    s.rsel = RI_NONE;
    s.port = 1'b0;
    lo     = a;
    if (a >= PORT_STRIDE && a < OFF_STAT) begin
      s.port = 1'b1;
      lo     = a - PORT_STRIDE;
    end
    if (a < OFF_STAT) begin
      case (lo)
        OFF_ADDR: s.rsel = RI_ADDR;
        OFF_CTRL: s.rsel = RI_CTRL;
        OFF_BAUD: s.rsel = RI_BAUD;
        OFF_TIME: s.rsel = RI_TIME;
        default:  s.rsel = RI_NONE;
      endcase
    end else begin
      case (a)
        OFF_STAT: s.rsel = RI_STAT;
        OFF_MASK: s.rsel = RI_MASK;
        OFF_ACTV: s.rsel = RI_ACTV;
        default:  s.rsel = RI_NONE;
      endcase
    end
    return s;
  endfunction

  function automatic ssp_cfg_type cfg_reset();
    ssp_cfg_type c;
    c             = '0;
    c.station     = STN_RST;
    c.start_pwr   = 1'b0;
    c.rtu         = 1'b0;
    c.data_code   = DBITS_RST;
    c.parity      = PAR_RST;
    c.stop2       = 1'b0;
    c.baud_idx    = BAUD_IDX_RST;
    c.custom_rate = CUST_RST;
    c.reply_ms    = REPLY_RST;
    c.tmo_ms      = TMO_RST;
    return c;
  endfunction

  localparam ssp_cfg_type CFG_RST = cfg_reset();

  ssp_sel_type                   sel;
  logic                          wr_en;
  logic                          rd_setup;
  ssp_cfg_type [PORTS-1:0]       cfg_ff, nxt_cfg;
  logic [31:0]                   stat_ff, nxt_stat;
  logic [31:0]                   mask_ff, nxt_mask;
  logic [31:0]                   rdata_ff, nxt_rdata;
  logic [31:0]                   stat_set;
  logic [PRE_W-1:0]              pre_ff, nxt_pre;
  logic                          tick_ff, nxt_tick;
  logic                          irq_ff, nxt_irq;
  ssp_evt_type [PORTS-1:0]       evt;

  // --------------------------------------------------------------
  // millisecond tick
  // --------------------------------------------------------------
  always_comb begin
    nxt_tick = (pre_ff == PRE_LAST);
    nxt_pre  = nxt_tick ? '0 : pre_ff + PRE_W'(1);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_ff  <= '0;
      tick_ff <= 1'b0;
    end else begin
      pre_ff  <= nxt_pre;
      tick_ff <= nxt_tick;
    end
  end

  // --------------------------------------------------------------
  // register file
  // --------------------------------------------------------------
  always_comb begin
    sel      = reg_sel(paddr);
    wr_en    = psel && penable && pwrite && (sel.rsel != RI_NONE);
    rd_setup = psel && !penable && !pwrite;
    nxt_cfg  = cfg_ff;
    nxt_mask = mask_ff;
    stat_set = '0;
    for (int p = 0; p < PORTS; p++) begin
      stat_set[p*STAT_STRIDE +: 5] = evt[p];
      if (wr_en && sel.port == 1'(p)) begin
        case (sel.rsel)
          RI_ADDR: begin
            // out-of-range and zero addresses are refused
            if (pwdata[7:0] >= STN_MIN
                && pwdata[7:0] <= STN_MAX) begin
              nxt_cfg[p].station = pwdata[7:0];
            end
          end
          RI_CTRL: begin
            nxt_cfg[p].start_pwr = pwdata[CTRL_PWR];
            nxt_cfg[p].master    = pwdata[CTRL_MST];
            nxt_cfg[p].rtu       = pwdata[CTRL_RTU];
            nxt_cfg[p].data_code = pwdata[CTRL_DB_LO +: 2];
            nxt_cfg[p].parity    = pwdata[CTRL_PAR_LO +: 2];
            nxt_cfg[p].stop2     = pwdata[CTRL_STOP2];
          end
          RI_BAUD: begin
            nxt_cfg[p].baud_idx    = pwdata[3:0];
            nxt_cfg[p].baud_custom = pwdata[BAUD_CUST];
            if (pwdata[BAUD_RATE_LO +: 13] >= CUST_MIN
                && pwdata[BAUD_RATE_LO +: 13] <= CUST_MAX) begin
              nxt_cfg[p].custom_rate = pwdata[BAUD_RATE_LO +: 13];
            end
          end
          RI_TIME: begin
            if (pwdata[11:0] <= MS_MAX) begin
              nxt_cfg[p].reply_ms = pwdata[11:0];
            end
            if (pwdata[TIME_TMO_LO +: 12] <= MS_MAX) begin
              nxt_cfg[p].tmo_ms = pwdata[TIME_TMO_LO +: 12];
            end
          end
          default: nxt_cfg[p] = cfg_ff[p];
        endcase
      end
    end
    if (wr_en && sel.rsel == RI_MASK) begin
      nxt_mask = pwdata;
    end
    // hardware set wins over a same-cycle write-one clear
    nxt_stat = stat_ff;
    if (wr_en && sel.rsel == RI_STAT) begin
      nxt_stat = stat_ff & ~pwdata;
    end
    nxt_stat = nxt_stat | stat_set;
    nxt_irq  = |(nxt_stat & nxt_mask);
    nxt_rdata = rdata_ff;
    if (rd_setup) begin
      nxt_rdata = '0;
      case (sel.rsel)
        RI_ADDR: nxt_rdata[7:0] = cfg_ff[sel.port].station;
        RI_CTRL: begin
          nxt_rdata[CTRL_PWR]         = cfg_ff[sel.port].start_pwr;
          nxt_rdata[CTRL_MST]         = cfg_ff[sel.port].master;
          nxt_rdata[CTRL_RTU]         = cfg_ff[sel.port].rtu;
          nxt_rdata[CTRL_DB_LO +: 2]  = cfg_ff[sel.port].data_code;
          nxt_rdata[CTRL_PAR_LO +: 2] = cfg_ff[sel.port].parity;
          nxt_rdata[CTRL_STOP2]       = cfg_ff[sel.port].stop2;
        end
        RI_BAUD: begin
          nxt_rdata[3:0]                = cfg_ff[sel.port].baud_idx;
          nxt_rdata[BAUD_CUST]          = cfg_ff[sel.port].baud_custom;
          nxt_rdata[BAUD_RATE_LO +: 13] = cfg_ff[sel.port].custom_rate;
        end
        RI_TIME: begin
          nxt_rdata[11:0]              = cfg_ff[sel.port].reply_ms;
          nxt_rdata[TIME_TMO_LO +: 12] = cfg_ff[sel.port].tmo_ms;
        end
        RI_STAT: nxt_rdata = stat_ff;
        RI_MASK: nxt_rdata = mask_ff;
        RI_ACTV: nxt_rdata[PORTS-1:0] = port_active;
        default: nxt_rdata = '0;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int p = 0; p < PORTS; p++) begin
        cfg_ff[p] <= CFG_RST;
      end
      stat_ff  <= '0;
      mask_ff  <= '0;
      rdata_ff <= '0;
      irq_ff   <= 1'b0;
    end else begin
      cfg_ff   <= nxt_cfg;
      stat_ff  <= nxt_stat;
      mask_ff  <= nxt_mask;
      rdata_ff <= nxt_rdata;
      irq_ff   <= nxt_irq;
    end
  end

  assign prdata   = rdata_ff;
  assign pready   = 1'b1;
  assign pslverr  = psel && penable && (sel.rsel == RI_NONE);
  assign irq      = irq_ff;
  assign port_cfg = cfg_ff;

  // --------------------------------------------------------------
  // port instances
  // --------------------------------------------------------------
  for (genvar g = 0; g < PORTS; g++) begin : g_port
    ssp_port u_port (
      .clk      (pclk),
      .rst_n    (presetn),
      .cfg      (cfg_ff[g]),
      .cpu_run  (cpu_run),
      .ms_tick  (tick_ff),
      .frame    (rx_frame[g]),
      .req_sent (req_sent[g]),
      .resp_rx  (resp_rx[g]),
      .active   (port_active[g]),
      .reply_go (reply_go[g]),
      .evt      (evt[g])
    );
  end

  // --------------------------------------------------------------
  // checks
  // --------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  chk_addr_range: assert property (
    cfg_ff[0].station >= STN_MIN && cfg_ff[0].station <= STN_MAX
    && cfg_ff[1].station >= STN_MIN && cfg_ff[1].station <= STN_MAX)
    else $error("station address out of range");
  chk_station_write: assert property (
    wr_en && sel.rsel == RI_ADDR && pwdata[7:0] >= STN_MIN
    && pwdata[7:0] <= STN_MAX
    |=> cfg_ff[$past(sel.port)].station == $past(pwdata[7:0]))
    else $error("valid station write not stored");
  chk_bad_station: assert property (
    wr_en && sel.rsel == RI_ADDR
    && (pwdata[7:0] == STN_BCAST || pwdata[7:0] > STN_MAX)
    |=> $stable(cfg_ff[0].station) && $stable(cfg_ff[1].station))
    else $error("refused station value was stored");
  chk_custom_range: assert property (
    cfg_ff[0].custom_rate >= CUST_MIN && cfg_ff[0].custom_rate <= CUST_MAX
    && cfg_ff[1].custom_rate >= CUST_MIN
    && cfg_ff[1].custom_rate <= CUST_MAX)
    else $error("custom baud out of range");
  chk_delay_range: assert property (
    cfg_ff[0].reply_ms <= MS_MAX && cfg_ff[1].reply_ms <= MS_MAX)
    else $error("reply delay out of range");
  chk_tmo_range: assert property (
    cfg_ff[0].tmo_ms <= MS_MAX && cfg_ff[1].tmo_ms <= MS_MAX)
    else $error("timeout out of range");
  chk_port_split: assert property (
    wr_en && sel.rsel == RI_ADDR && !sel.port
    |=> $stable(cfg_ff[1].station))
    else $error("port 0 write disturbed port 1");
  chk_irq_follow: assert property (
    evt[0].bcast && mask_ff[1] |=> irq)
    else $error("masked-in event gave no interrupt");
  chk_set_wins: assert property (
    (|stat_set) |=> (stat_ff & $past(stat_set)) == $past(stat_set))
    else $error("status event lost to a same-cycle clear");
  chk_w1c_clear: assert property (
    wr_en && sel.rsel == RI_STAT && stat_set == '0
    |=> (stat_ff & $past(pwdata)) == '0)
    else $error("write-one did not clear status");
  cov_both_active: cover property (@(posedge pclk) &port_active);
  cov_irq_clear: cover property (@(posedge pclk) $fell(irq));

endmodule

// ==== rtl/ssp_pkg.sv ====
// shared constants and types for the serial station port block
package ssp_pkg;

  localparam int PORTS = 2;

  // --------------------------------------------------------------
  // register map (byte addresses, port 1 at base plus stride)
  // --------------------------------------------------------------
  localparam logic [7:0] OFF_ADDR    = 8'h00;
  localparam logic [7:0] OFF_CTRL    = 8'h04;
  localparam logic [7:0] OFF_BAUD    = 8'h08;
  localparam logic [7:0] OFF_TIME    = 8'h0C;
  localparam logic [7:0] PORT_STRIDE = 8'h20;
  localparam logic [7:0] OFF_STAT    = 8'h40;
  localparam logic [7:0] OFF_MASK    = 8'h44;
  localparam logic [7:0] OFF_ACTV    = 8'h48;

  // --------------------------------------------------------------
  // field positions
  // --------------------------------------------------------------
  localparam int CTRL_PWR     = 0;
  localparam int CTRL_MST     = 1;
  localparam int CTRL_RTU     = 2;
  localparam int CTRL_DB_LO   = 4;
  localparam int CTRL_PAR_LO  = 6;
  localparam int CTRL_STOP2   = 8;
  localparam int BAUD_CUST    = 4;
  localparam int BAUD_RATE_LO = 16;
  localparam int TIME_TMO_LO  = 16;
  localparam int STAT_STRIDE  = 8;

  // --------------------------------------------------------------
  // limits and reset values
  // --------------------------------------------------------------
  localparam logic [7:0]  STN_BCAST    = 8'h00;
  localparam logic [7:0]  STN_MIN      = 8'h01;
  localparam logic [7:0]  STN_MAX      = 8'hFE;
  localparam logic [7:0]  STN_RST      = 8'h01;
  localparam logic [12:0] CUST_MIN     = 13'h0001;
  localparam logic [12:0] CUST_MAX     = 13'h1388;
  localparam logic [12:0] CUST_RST     = 13'h0060;
  localparam logic [3:0]  BAUD_IDX_RST = 4'h4;
  localparam logic [11:0] MS_MAX       = 12'hBB8;
  localparam logic [11:0] REPLY_RST    = 12'h000;
  localparam logic [11:0] TMO_RST      = 12'h0C8;
  localparam logic [1:0]  DBITS_RST    = 2'h2;
  localparam logic [1:0]  PAR_RST      = 2'h2;

  // --------------------------------------------------------------
  // timing
  // --------------------------------------------------------------
  localparam int CLK_NS    = 40;
  localparam int MS_NS     = 1000000;
  localparam int MS_CYCLES = MS_NS / CLK_NS;

  // --------------------------------------------------------------
  // types
  // --------------------------------------------------------------
  typedef struct packed {
    logic [7:0]  station;
    logic        start_pwr;
    logic        master;
    logic        rtu;
    logic [1:0]  data_code;
    logic [1:0]  parity;
    logic        stop2;
    logic [3:0]  baud_idx;
    logic        baud_custom;
    logic [12:0] custom_rate;
    logic [11:0] reply_ms;
    logic [11:0] tmo_ms;
  } ssp_cfg_type;

  typedef struct packed {
    logic       valid;
    logic [7:0] addr;
  } ssp_frame_type;

  typedef struct packed {
    logic tmo;
    logic reply;
    logic discard;
    logic bcast;
    logic accept;
  } ssp_evt_type;

  typedef enum logic [2:0] {
    RI_ADDR, RI_CTRL, RI_BAUD, RI_TIME, RI_STAT, RI_MASK, RI_ACTV, RI_NONE
  } ssp_reg_type;

  typedef struct packed {
    ssp_reg_type rsel;
    logic        port;
  } ssp_sel_type;

endpackage

// ==== rtl/ssp_port.sv ====
// per-port station filter, start control, reply delay and timeout
`timescale 1ns/1ns
module ssp_port import ssp_pkg::*; (
  // clock and reset
  input  wire logic          clk,
  input  wire logic          rst_n,
  // configuration and system state
  input  wire ssp_cfg_type   cfg,
  input  wire logic          cpu_run,
  input  wire logic          ms_tick,
  // link side
  input  wire ssp_frame_type frame,
  input  wire logic          req_sent,
  input  wire logic          resp_rx,
  // results
  output logic               active,
  output logic               reply_go,
  output ssp_evt_type        evt
);

  typedef enum logic {RS_IDLE, RS_WAIT} ssp_rs_type;

  ssp_rs_type  rs_ff,      nxt_rs;
  logic        run_prev_ff, nxt_run_prev;
  logic        active_ff,  nxt_active;
  logic [11:0] rep_cnt_ff, nxt_rep_cnt;
  logic        tmo_run_ff, nxt_tmo_run;
  logic [11:0] tmo_cnt_ff, nxt_tmo_cnt;
  logic        reply_ff,   nxt_reply;
  ssp_evt_type evt_ff,     nxt_evt;
  logic        listen;
  logic        hit_own;
  logic        hit_bc;

  always_comb begin
    listen  = frame.valid && active_ff && !cfg.master;
    hit_own = listen && (frame.addr == cfg.station);
    hit_bc  = listen && (frame.addr == STN_BCAST);
    nxt_run_prev = cpu_run;
    // latch start on power-on option or stop to run edge
    nxt_active = active_ff || cfg.start_pwr
                 || (cpu_run && !run_prev_ff);
    nxt_evt         = '0;
    nxt_evt.accept  = hit_own;
    nxt_evt.bcast   = hit_bc;
    nxt_evt.discard = listen && !hit_own && !hit_bc;
    nxt_rs      = rs_ff;
    nxt_rep_cnt = rep_cnt_ff;
    nxt_reply   = 1'b0;
    case (rs_ff)
      RS_IDLE: begin
        // broadcast never enters the reply path
        if (hit_own) begin
          nxt_rs      = RS_WAIT;
          nxt_rep_cnt = '0;
        end
      end
      RS_WAIT: begin
        if (rep_cnt_ff >= cfg.reply_ms) begin
          nxt_reply = 1'b1;
          nxt_rs    = RS_IDLE;
        end else if (ms_tick) begin
          nxt_rep_cnt = rep_cnt_ff + 12'h001;
        end
      end
      default: nxt_rs = RS_IDLE;
    endcase
    nxt_evt.reply = nxt_reply;
    nxt_tmo_run = tmo_run_ff;
    nxt_tmo_cnt = tmo_cnt_ff;
    if (!active_ff || !cfg.master) begin
      nxt_tmo_run = 1'b0;
    end else if (req_sent) begin
      nxt_tmo_run = 1'b1;
      nxt_tmo_cnt = '0;
    end else if (tmo_run_ff) begin
      if (resp_rx) begin
        nxt_tmo_run = 1'b0;
      end else if (cfg.tmo_ms != 12'h000
                   && tmo_cnt_ff >= cfg.tmo_ms) begin
        nxt_tmo_run = 1'b0;
        nxt_evt.tmo = 1'b1;
      end else if (ms_tick) begin
        nxt_tmo_cnt = tmo_cnt_ff + 12'h001;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rs_ff       <= RS_IDLE;
      run_prev_ff <= 1'b0;
      active_ff   <= 1'b0;
      rep_cnt_ff  <= '0;
      tmo_run_ff  <= 1'b0;
      tmo_cnt_ff  <= '0;
      reply_ff    <= 1'b0;
      evt_ff      <= '0;
    end else begin
      rs_ff       <= nxt_rs;
      run_prev_ff <= nxt_run_prev;
      active_ff   <= nxt_active;
      rep_cnt_ff  <= nxt_rep_cnt;
      tmo_run_ff  <= nxt_tmo_run;
      tmo_cnt_ff  <= nxt_tmo_cnt;
      reply_ff    <= nxt_reply;
      evt_ff      <= nxt_evt;
    end
  end

  assign active   = active_ff;
  assign reply_go = reply_ff;
  assign evt      = evt_ff;

  // --------------------------------------------------------------
  // checks
  // --------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  chk_inactive_quiet: assert property (
    !active_ff |=> !evt_ff.accept && !evt_ff.bcast && !reply_ff)
    else $error("frame handled while port not started");
  chk_pwr_start: assert property (
    cfg.start_pwr |=> active_ff)
    else $error("power-on start did not activate port");
  chk_run_edge: assert property (
    $rose(cpu_run) && $past(rst_n) |=> active_ff)
    else $error("stop to run edge did not activate port");
  chk_bcast_take: assert property (
    listen && frame.addr == STN_BCAST |=> evt_ff.bcast && !evt_ff.accept)
    else $error("broadcast frame not accepted");
  chk_foreign_drop: assert property (
    listen && frame.addr != STN_BCAST && frame.addr != cfg.station
    |=> evt_ff.discard && !evt_ff.accept)
    else $error("foreign frame not discarded");
  chk_zero_delay: assert property (
    hit_own && rs_ff == RS_IDLE && cfg.reply_ms == 12'h000
    && $stable(cfg.reply_ms) |-> ##2 reply_ff)
    else $error("zero reply delay not honoured");
  chk_tmo_off: assert property (
    cfg.tmo_ms == 12'h000 && $stable(cfg.tmo_ms) |=> !evt_ff.tmo)
    else $error("timeout raised while disabled");
  cov_bcast: cover property (evt_ff.bcast);
  cov_reply: cover property (reply_ff && cfg.reply_ms != 12'h000);
  cov_tmo:   cover property (evt_ff.tmo);

endmodule

// ==== dv/ssp_link_master.sv ====
// link-side model of the serial master and the other stations
`timescale 1ns/1ns
module ssp_link_master import ssp_pkg::*; (
  // clock
  input  wire logic          pclk,
  // link side
  output ssp_frame_type [PORTS-1:0] rx_frame,
  output logic [PORTS-1:0]          req_sent,
  output logic [PORTS-1:0]          resp_rx
);
  initial begin
    rx_frame = '0;
    req_sent = '0;
    resp_rx  = '0;
  end

  // one frame cycle, address inverted once released
  task automatic send_frame(input int p, input logic [7:0] a);
    @(posedge pclk);
    rx_frame[p] <= '{valid: 1'b1, addr: a};
    @(posedge pclk);
    rx_frame[p] <= '{valid: 1'b0, addr: ~a};
  endtask

  // request sent (resp=0) or response arrived (resp=1)
  task automatic pulse_req(input int p, input bit resp);
    @(posedge pclk);
    if (resp) resp_rx[p] <= 1'b1;
    else req_sent[p] <= 1'b1;
    @(posedge pclk);
    resp_rx[p]  <= 1'b0;
    req_sent[p] <= 1'b0;
  endtask
endmodule

// ==== dv/tb_ssp_top.sv ====
// self-checking bench for the two serial station ports
`timescale 1ns/1ns
module tb_ssp_top import ssp_pkg::*; ;
  localparam int MSC = 10;
  logic                      pclk, presetn, psel, penable, pwrite;
  logic                      pready, pslverr, cpu_run, irq, err;
  logic [7:0]                paddr;
  logic [31:0]               pwdata, prdata, rd;
  ssp_frame_type [PORTS-1:0] rx_frame;
  logic [PORTS-1:0]          req_sent, resp_rx, reply_go, port_active;
  int                        error_cnt, num_checks, cyc, t0, stn1;
  int                        nrep[PORTS], trep[PORTS];
  logic [31:0]               rv[4];
  int                        mstat, mact, mrep[PORTS], mstn[PORTS];
  ssp_cfg_type [PORTS-1:0]   port_cfg;

  ssp_top #(.MS_CYC(MSC)) uut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .cpu_run(cpu_run),
    .rx_frame(rx_frame), .req_sent(req_sent), .resp_rx(resp_rx),
    .reply_go(reply_go), .port_active(port_active), .port_cfg(port_cfg),
    .irq(irq));

  ssp_link_master lm (.pclk(pclk), .rx_frame(rx_frame),
    .req_sent(req_sent), .resp_rx(resp_rx));

  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  // reply pulse count and arrival cycle per port
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    for (int p = 0; p < PORTS; p++) begin
      if (reply_go[p] === 1'b1) begin
        nrep[p]++;
        trep[p] = cyc;
      end
    end
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  // rule model of one frame: filter, broadcast, reply count
  task automatic frame(input int p, input logic [7:0] a);
    lm.send_frame(p, a);
    if (mact != 0) begin
      if (a == STN_BCAST) begin
        mstat |= 32'h2 << (p * STAT_STRIDE);
      end else if (32'(a) == mstn[p]) begin
        mstat |= 32'h9 << (p * STAT_STRIDE);
        mrep[p]++;
      end else begin
        mstat |= 32'h4 << (p * STAT_STRIDE);
      end
    end
  endtask

  task automatic give_verdict();
    $display("checks=%0d errors=%0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  initial begin
    repeat (5000) @(posedge pclk);
    error_cnt++;
    give_verdict();
  end

  initial begin
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = '0; pwdata = '0; cpu_run = 1'b0;
    void'($urandom(4));
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    // --------------------------------------------------------
    // reset values of both ports, unmapped access
    // --------------------------------------------------------
    rv = '{32'h1, 32'hA0, 32'h0060_0004, 32'h00C8_0000};
    for (int p = 0; p < PORTS; p++) begin
      for (int i = 0; i < 4; i++) begin
        apb(1'b0, 8'(p * 32 + i * 4), '0);
        check(rd, rv[i]);
      end
    end
    apb(1'b0, 8'h50, '0);
    check({err, rd[30:0]}, 32'h8000_0000);
    // --------------------------------------------------------
    // station address per port, out-of-range refused
    // --------------------------------------------------------
    stn1 = 1 + ($urandom % 254);
    apb(1'b1, PORT_STRIDE, 32'(stn1));
    apb(1'b1, PORT_STRIDE, 32'h0);
    apb(1'b1, PORT_STRIDE, 32'hFF);
    apb(1'b0, PORT_STRIDE, '0);
    check(rd, 32'(stn1));
    apb(1'b0, OFF_ADDR, '0);
    check(rd, 32'h1);
    check(32'(port_cfg[1].station), 32'(stn1));
    check(32'(port_cfg[0].data_code), 32'(DBITS_RST));
    check(32'(port_cfg[0].parity), 32'(PAR_RST));
    mstn[0] = STN_RST;
    mstn[1] = stn1;
    apb(1'b1, OFF_MASK, 32'h1F);
    // --------------------------------------------------------
    // silent until stop-to-run
    // --------------------------------------------------------
    lm.send_frame(0, 8'h01);
    repeat (6) @(posedge pclk);
    check({30'h0, port_active}, 32'h0);
    check(32'(nrep[0]), 32'h0);
    cpu_run <= 1'b1;
    mact = 1;
    repeat (3) @(posedge pclk);
    apb(1'b0, OFF_ACTV, '0);
    check(rd, 32'h3);
    // --------------------------------------------------------
    // own, broadcast, foreign frames; status and irq
    // --------------------------------------------------------
    frame(0, 8'h01);
    frame(0, 8'h00);
    frame(0, 8'h63);
    frame(1, stn1[7:0]);
    frame(1, 8'h00);
    repeat (6) @(posedge pclk);
    apb(1'b0, OFF_STAT, '0);
    check(rd, 32'h0000_0B0F);
    check(rd, mstat);
    check(32'(nrep[0] * 16 + nrep[1]), 32'h11);
    check(32'(nrep[1]), 32'(mrep[1]));
    check({31'h0, irq}, 32'h1);
    apb(1'b1, OFF_STAT, 32'h0000_0B0F);
    mstat = 0;
    repeat (3) @(posedge pclk);
    apb(1'b0, OFF_STAT, '0);
    check({irq, rd[30:0]}, 32'h0);
    // --------------------------------------------------------
    // reply delay of 2 ms on port 0
    // --------------------------------------------------------
    apb(1'b1, OFF_TIME, 32'h00C8_0002);
    t0 = cyc;
    frame(0, 8'h01);
    repeat (3 * MSC + 5) @(posedge pclk);
    check(32'(nrep[0]), 32'h2);
    check(32'(nrep[0]), 32'(mrep[0]));
    check(32'(trep[0] - t0 >= MSC && trep[0] - t0 <= 2 * MSC + 4),
          32'h1);
    apb(1'b0, OFF_STAT, '0);
    check(rd, mstat);
    apb(1'b1, OFF_STAT, mstat);
    mstat = 0;
    // --------------------------------------------------------
    // receive timeout on port 1 as master, masked
    // --------------------------------------------------------
    apb(1'b1, PORT_STRIDE + OFF_CTRL, 32'hA2);
    apb(1'b1, PORT_STRIDE + OFF_TIME, 32'h0002_0000);
    lm.pulse_req(1, 1'b0);
    repeat (2) @(posedge pclk);
    lm.pulse_req(1, 1'b1);
    repeat (4 * MSC) @(posedge pclk);
    apb(1'b0, OFF_STAT, '0);
    check(rd, 32'h0);
    lm.pulse_req(1, 1'b0);
    repeat (4 * MSC) @(posedge pclk);
    apb(1'b0, OFF_STAT, '0);
    check({irq, rd[30:0]}, 32'h0000_1000);
    // timeout value zero never fires
    apb(1'b1, OFF_STAT, 32'h0000_1000);
    apb(1'b1, PORT_STRIDE + OFF_TIME, '0);
    lm.pulse_req(1, 1'b0);
    repeat (4 * MSC) @(posedge pclk);
    apb(1'b0, OFF_STAT, '0);
    check(rd, 32'h0);
    // second reset, controller stopped, then power-on start
    cpu_run <= 1'b0;
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, OFF_ACTV, '0);
    check(rd, 32'h0);
    apb(1'b1, OFF_CTRL, 32'h0000_00A1);
    apb(1'b0, OFF_ACTV, '0);
    check(rd, 32'h1);
    give_verdict();
  end
endmodule
